// ==== src/rfr_pkg.sv ====
// shared constants for the remote bus frame receiver
package rfr_pkg;
    localparam logic [7:0] SYNC_CHAR = 8'h16;
    localparam logic [7:0] BCAST_ID = 8'h00;
    localparam logic [7:0] RSV_ID_LO = 8'h1c;
    localparam logic [7:0] RSV_ID_HI = 8'h1f;
    localparam logic [15:0] RESP_GOOD = 16'h0000;
    localparam logic [15:0] RESP_BAD_CSUM = 16'h00fd;
    localparam logic [15:0] CNT_FIELD_BYTES = 16'h0002;
    localparam int unsigned CLK_KHZ = 100000;
    localparam int unsigned GAP_MS = 200;
    localparam int unsigned WAIT_MS = 1000;
    localparam int unsigned GAP_CYC = GAP_MS * CLK_KHZ;
    localparam int unsigned WAIT_CYC = WAIT_MS * CLK_KHZ;
    localparam int unsigned FIFO_W = 8;
    localparam int unsigned FIFO_D = 4;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    typedef enum logic [3:0] {
        ST_HUNT = 4'h0,
        ST_CNT_HI = 4'h1,
        ST_CNT_LO = 4'h2,
        ST_SRC = 4'h3,
        ST_DST = 4'h4,
        ST_FSN = 4'h5,
        ST_OP_HI = 4'h6,
        ST_OP_LO = 4'h7,
        ST_DATA = 4'h8,
        ST_CSUM = 4'h9
    } rfr_state_t;
endpackage

// ==== src/rfr_frame_rx.sv ====
// frame receiver with address filter, timers and payload fifo
`timescale 1ns/1ps
// Summary of operation
// - accept and answer own type override id
// - broadcast executes but never gets response
// - type override answered despite same-type peers
// - reserved ids 28-31 never match type
// - bulk reply: count, parameters, then status
// - surplus data bytes ignored without error
// - optional command wait timeout with recovery
// - bad frame flagged, not executed, tag not tracked
// - foreign or bad frames counted to end
// - clean addressed frame executed and acknowledged
// - error reply unless wait timeout expired
// - inter-character timer declares receive timeout
// - discard bytes until sync character seen
// - check byte is mod 256 sum
// - count field locates data end, check byte
// - repeated sequence tag: answer, no execution

module rfr_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int unsigned CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic [CW-1:0] wr_idx;
    logic push;
    logic pop;

    // head sits in slot 0 so the output is a plain flop
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign wr_idx = pop ? count_q - CW'(1) : count_q;
    assign count_d = count_q + CW'(push) - CW'(pop);
    assign o_out_data = mem_q[0];

    always_ff @(posedge i_ref_clk)
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            if (push && CW'(i) == wr_idx)
                mem_q[i] <= i_in_data;
            else if (pop && i < DEPTH - 1)
                mem_q[i] <= mem_q[i+1];
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            count_q <= '0;
            o_in_ready <= 1'b1;
            o_out_valid <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            o_in_ready <= count_d < CW'(DEPTH);
            o_out_valid <= count_d != '0;
        end
    end
endmodule // rfr_fifo

module rfr_frame_rx
    import rfr_pkg::*;
#(
    // arbitrary type override id; must match the product's own code
    parameter logic [7:0] TYPE_ID = 8'h0b,
    parameter int unsigned GAP_CYCLES = GAP_CYC,
    parameter int unsigned WAIT_CYCLES = WAIT_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    output logic o_rx_ready,
    input wire logic [7:0] i_unit_addr,
    input wire logic [15:0] i_max_len,
    input wire logic i_wait_en,
    input wire logic [15:0] i_nv_len,
    input wire logic [15:0] i_st_len,
    output logic o_data_valid,
    output logic [7:0] o_data,
    input wire logic i_data_ready,
    output logic o_frame_done,
    output logic o_exec,
    output logic o_resp,
    output logic o_err,
    output logic [15:0] o_resp_code,
    output logic [15:0] o_resp_len,
    output logic [15:0] o_opcode,
    output logic [7:0] o_src_addr,
    output logic [7:0] o_fsn,
    output logic o_rx_timeout,
    output logic o_wait_expired
);
    rfr_state_t st_q;
    logic acc, hit_q, bcast_q, hit_d, type_ok, gap_fire, wait_fire;
    logic expired_q, seen_q, dup, csum_ok, end_acc, push;
    logic [7:0] sum_q, dst_q, last_src_q, last_fsn_q;
    logic [15:0] len_q, left_q, pushed_q;
    logic [24:0] gap_q;
    logic [26:0] wait_q;

    assign acc = i_rx_valid && o_rx_ready;
    assign end_acc = acc && st_q == ST_CSUM;
    assign csum_ok = i_rx_data == sum_q;
    assign dup = seen_q && last_src_q == o_src_addr && last_fsn_q == o_fsn;
    // reserved ids belong to no product, so never count as own type
    assign type_ok = !(TYPE_ID >= RSV_ID_LO && TYPE_ID <= RSV_ID_HI);
    assign hit_d = i_rx_data == i_unit_addr || i_rx_data == BCAST_ID
        || (type_ok && i_rx_data == TYPE_ID);
    // bytes beyond what the command task takes are dropped quietly
    assign push = acc && st_q == ST_DATA && hit_q
        && pushed_q < i_max_len;
    assign gap_fire = st_q != ST_HUNT && !acc
        && gap_q == 25'(GAP_CYCLES - 1);
    assign wait_fire = i_wait_en && st_q == ST_HUNT && !acc
        && wait_q == 27'(WAIT_CYCLES - 1);

    rfr_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_D)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_in_valid(push),
        .i_in_data(i_rx_data),
        .o_in_ready(o_rx_ready),
        .o_out_valid(o_data_valid),
        .o_out_data(o_data),
        .i_out_ready(i_data_ready)
    );

    // framing; a full fifo stalls every byte, not only payload
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            st_q <= ST_HUNT;
        else if (gap_fire)
            st_q <= ST_HUNT;
        else if (acc)
        begin
            case (st_q)
                ST_HUNT:
                    if (i_rx_data == SYNC_CHAR)
                        st_q <= ST_CNT_HI;
                ST_CNT_HI: st_q <= ST_CNT_LO;
                ST_CNT_LO: st_q <= ST_SRC;
                ST_SRC: st_q <= ST_DST;
                ST_DST: st_q <= ST_FSN;
                ST_FSN: st_q <= ST_OP_HI;
                ST_OP_HI: st_q <= ST_OP_LO;
                ST_OP_LO: st_q <= len_q == '0 ? ST_CSUM : ST_DATA;
                ST_DATA:
                    if (left_q == 16'h0001)
                        st_q <= ST_CSUM;
                ST_CSUM: st_q <= ST_HUNT;
                default: st_q <= ST_HUNT;
            endcase
        end
    end

    // header capture and running sum
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            sum_q <= RST_BYTE;
            len_q <= RST_WORD;
            left_q <= RST_WORD;
            pushed_q <= RST_WORD;
            dst_q <= RST_BYTE;
            hit_q <= 1'b0;
            bcast_q <= 1'b0;
            o_src_addr <= RST_BYTE;
            o_fsn <= RST_BYTE;
            o_opcode <= RST_WORD;
        end
        else if (acc)
        begin
            if (st_q == ST_HUNT)
                sum_q <= RST_BYTE;
            else if (st_q != ST_CSUM)
                sum_q <= sum_q + i_rx_data;
            case (st_q)
                ST_CNT_HI: len_q[15:8] <= i_rx_data;
                ST_CNT_LO: len_q[7:0] <= i_rx_data;
                ST_SRC: o_src_addr <= i_rx_data;
                ST_DST:
                begin
                    dst_q <= i_rx_data;
                    hit_q <= hit_d;
                    bcast_q <= i_rx_data == BCAST_ID;
                end
                ST_FSN: o_fsn <= i_rx_data;
                ST_OP_HI: o_opcode[15:8] <= i_rx_data;
                ST_OP_LO:
                begin
                    o_opcode[7:0] <= i_rx_data;
                    left_q <= len_q;
                    pushed_q <= RST_WORD;
                end
                ST_DATA:
                begin
                    left_q <= left_q - 16'h0001;
                    if (push)
                        pushed_q <= pushed_q + 16'h0001;
                end
                default: ;
            endcase
        end
    end

    // inter-character timer runs only inside a frame
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst || acc || st_q == ST_HUNT || gap_fire)
            gap_q <= '0;
        else
            gap_q <= gap_q + 25'h0000001;
    end

    // command wait timer runs while hunting between frames
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst || acc || !i_wait_en || st_q != ST_HUNT || wait_fire)
            wait_q <= '0;
        else
            wait_q <= wait_q + 27'h0000001;
    end

    // expiry set wins over the clear at frame end
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            expired_q <= 1'b0;
        else if (wait_fire)
            expired_q <= 1'b1;
        else if (end_acc)
            expired_q <= 1'b0;
    end

    // duplicate tracking of last executed tag and its originator (one entry)
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            seen_q <= 1'b0;
            last_src_q <= RST_BYTE;
            last_fsn_q <= RST_BYTE;
        end
        else if (end_acc && hit_q && csum_ok)
        begin
            seen_q <= 1'b1;
            last_src_q <= o_src_addr;
            last_fsn_q <= o_fsn;
        end
    end

    // frame verdict flags pulse for one cycle; response code and length hold until the next frame end
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_frame_done <= 1'b0;
            o_exec <= 1'b0;
            o_resp <= 1'b0;
            o_err <= 1'b0;
            o_resp_code <= RST_WORD;
            o_resp_len <= RST_WORD;
            o_rx_timeout <= 1'b0;
            o_wait_expired <= 1'b0;
        end
        else
        begin
            o_frame_done <= end_acc;
            o_rx_timeout <= gap_fire;
            o_wait_expired <= wait_fire;
            // same-type peers never silence a type id reply
            o_exec <= end_acc && hit_q && csum_ok && !dup;
            o_resp <= end_acc && hit_q && !bcast_q
                && (csum_ok || !expired_q);
            o_err <= end_acc && hit_q && !csum_ok;
            if (end_acc)
            begin
                o_resp_code <= csum_ok ? RESP_GOOD : RESP_BAD_CSUM;
                // bulk reply: count field, parameter block, status block
                o_resp_len <= CNT_FIELD_BYTES + i_nv_len + i_st_len;
            end
        end
    end

    bcast_silent_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_resp |-> dst_q != BCAST_ID)
        else $error("response sent for broadcast frame");
    type_answer_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (end_acc && csum_ok && type_ok && dst_q == TYPE_ID
        && dst_q != BCAST_ID) |=> o_resp && o_resp_code == RESP_GOOD)
        else $error("type override frame not answered");
    reserved_id_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (acc && st_q == ST_DST && i_rx_data >= RSV_ID_LO
        && i_rx_data <= RSV_ID_HI && i_rx_data != i_unit_addr)
        |=> !hit_q)
        else $error("reserved id matched");
    gap_abort_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        gap_fire |=> st_q == ST_HUNT && o_rx_timeout && !o_resp)
        else $error("gap timeout did not abandon frame");
    gap_bound_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_rx_timeout |-> $past(gap_q) == 25'(GAP_CYCLES - 1))
        else $error("gap timeout at wrong count");
    csum_err_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (end_acc && !csum_ok && hit_q && !bcast_q && !expired_q)
        |=> o_resp && o_err && !o_exec
        && o_resp_code == RESP_BAD_CSUM)
        else $error("bad checksum not reported");
    dup_tag_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (end_acc && csum_ok && hit_q && !bcast_q && dup)
        |=> o_resp && !o_exec)
        else $error("duplicate executed or not answered");
    foreign_quiet_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (end_acc && !hit_q) |=> !o_resp && !o_exec && !o_err)
        else $error("foreign frame acted upon");
    hunt_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (st_q == ST_HUNT && acc && i_rx_data != SYNC_CHAR)
        |=> st_q == ST_HUNT)
        else $error("left hunt without sync");
    data_end_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (st_q == ST_DATA && acc && left_q == 16'h0001 && !gap_fire)
        ##1 (acc && !gap_fire) |=> st_q == ST_HUNT)
        else $error("frame end not tracked by count");
    surplus_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (acc && st_q == ST_DATA && pushed_q >= i_max_len)
        |-> !push)
        else $error("surplus byte forwarded");

    good_frame_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
        o_exec && o_resp);
    bcast_frame_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
        o_exec && !o_resp);
    timeout_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
        o_rx_timeout);
    stall_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
        !o_rx_ready ##1 o_rx_ready);
endmodule // rfr_frame_rx

// ==== dv/rfr_host_model.sv ====
// host model that sends command bytes to the frame receiver
`timescale 1ns/1ps
module rfr_host_model (
    input wire logic i_ref_clk,
    input wire logic i_ready,
    output logic o_valid,
    output logic [7:0] o_data
);
    int unsigned gap = 0;
    initial
    begin
        o_valid = 1'b0;
        o_data = 8'hff;
    end
    // a byte is held until taken; an idle line shows the inverse of the
    // last byte so a stale value never passes for a fresh one
    task automatic send(input logic [7:0] b[$]);
        foreach (b[i])
        begin
            o_valid <= 1'b1;
            o_data <= b[i];
            do @(posedge i_ref_clk); while (i_ready !== 1'b1);
            if (gap != 0 || i == b.size() - 1)
            begin
                o_valid <= 1'b0;
                o_data <= ~b[i];
                repeat (gap) @(posedge i_ref_clk);
            end
        end
        repeat (4) @(posedge i_ref_clk);
    endtask
endmodule // rfr_host_model

// ==== dv/tb.sv ====
// self-checking bench for the frame receiver
`timescale 1ns/1ps
module tb;
    import rfr_pkg::*;
    typedef logic [7:0] rfr_bq_t[$];
    localparam logic [7:0] TYPE_T = 8'h0b; // arbitrary type id
    localparam int unsigned GAP_T = 40;
    localparam int unsigned WAIT_T = 60;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic rx_valid, rx_ready, i_wait_en = 1'b0, i_data_ready = 1'b1;
    logic [7:0] rx_data, o_data, o_src_addr, o_fsn;
    logic [15:0] i_max_len = 16'h0008, o_resp_code, o_resp_len, o_opcode;
    logic o_data_valid, o_frame_done, o_exec, o_resp, o_err;
    logic o_rx_timeout, o_wait_expired, full_seen, exec2, resp2;
    int err_total = 0, checks = 0;
    int n[8] = '{default: 0}, b[8];
    rfr_bq_t rx_q;
    initial forever #5 i_ref_clk = ~i_ref_clk;
    rfr_host_model host (.i_ref_clk(i_ref_clk), .i_ready(rx_ready),
        .o_valid(rx_valid), .o_data(rx_data));
    rfr_frame_rx #(.TYPE_ID(TYPE_T), .GAP_CYCLES(GAP_T),
        .WAIT_CYCLES(WAIT_T)) DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_rx_valid(rx_valid), .i_rx_data(rx_data), .o_rx_ready(rx_ready),
        .i_unit_addr(8'h05), .i_max_len(i_max_len), .i_wait_en(i_wait_en),
        .i_nv_len(16'h0010), .i_st_len(16'h0008),
        .o_data_valid(o_data_valid), .o_data(o_data),
        .i_data_ready(i_data_ready), .o_frame_done(o_frame_done),
        .o_exec(o_exec), .o_resp(o_resp), .o_err(o_err),
        .o_resp_code(o_resp_code), .o_resp_len(o_resp_len),
        .o_opcode(o_opcode), .o_src_addr(o_src_addr), .o_fsn(o_fsn),
        .o_rx_timeout(o_rx_timeout), .o_wait_expired(o_wait_expired));
    // second unit with a reserved type id; it sees only bytes DUT took
    rfr_frame_rx #(.TYPE_ID(8'h1f), .GAP_CYCLES(GAP_T),
        .WAIT_CYCLES(WAIT_T)) DUT_RSV (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_rx_valid(rx_valid && rx_ready), .i_rx_data(rx_data),
        .o_rx_ready(), .i_unit_addr(8'h07),
        .i_max_len(16'h0000), .i_wait_en(i_wait_en),
        .i_nv_len(16'h0010), .i_st_len(16'h0008), .o_data_valid(),
        .o_data(), .i_data_ready(i_data_ready), .o_frame_done(),
        .o_exec(exec2), .o_resp(resp2), .o_err(), .o_resp_code(),
        .o_resp_len(), .o_opcode(), .o_src_addr(), .o_fsn(),
        .o_rx_timeout(), .o_wait_expired());
    // pulse tally: exec, resp, err, done, timeout, wait expired,
    // then exec and resp of the reserved-type unit
    always @(posedge i_ref_clk)
    begin
        n[0] += (o_exec === 1'b1);
        n[1] += (o_resp === 1'b1);
        n[2] += (o_err === 1'b1);
        n[3] += (o_frame_done === 1'b1);
        n[4] += (o_rx_timeout === 1'b1);
        n[5] += (o_wait_expired === 1'b1);
        n[6] += (exec2 === 1'b1);
        n[7] += (resp2 === 1'b1);
        if (o_data_valid === 1'b1 && i_data_ready === 1'b1)
            rx_q.push_back(o_data);
    end
    task automatic chk_cnt(input int got, input int exp, input string m);
        checks++;
        if (got != exp)
        begin
            err_total++;
            $display("unexpected at %0t: %s got %0d exp %0d", $time, m,
                got, exp);
        end
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp,
        input string m);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got,
                exp);
        end
    endtask
    task automatic mark();
        b = n;
        rx_q.delete();
    endtask
    task automatic expect_ev(input int e, input int r, input int x);
        chk_cnt(n[0] - b[0], e, "exec pulses");
        chk_cnt(n[1] - b[1], r, "response pulses");
        chk_cnt(n[2] - b[2], x, "error pulses");
        chk_cnt(n[3] - b[3], 1, "frame end pulses");
    endtask
    // checksum is the byte sum after the sync character
    function automatic rfr_bq_t mk(input logic [7:0] dst,
        input logic [7:0] frame_sequence_tag, input int cnt, input logic bad);
        rfr_bq_t q;
        logic [7:0] s;
        q = {8'h00, cnt[7:0], 8'h21, dst, frame_sequence_tag, 8'h20, 8'h01};
        for (int i = 0; i < cnt; i++)
            q.push_back(8'ha0 + i[7:0]);
        s = 8'h00;
        foreach (q[i])
            s += q[i];
        q.push_back(bad ? ~s : s);
        q.push_front(SYNC_CHAR);
        return q;
    endfunction
    task automatic t_good();
        i_max_len <= 16'h0001;
        mark();
        host.send(mk(8'h05, 8'h01, 2, 1'b0));
        expect_ev(1, 1, 0);
        chk_val(o_resp_code, RESP_GOOD, "response code");
        chk_val(o_resp_len, 16'h001a, "bulk reply length");
        chk_val(o_opcode, 16'h2001, "opcode");
        chk_val({o_src_addr, o_fsn}, 16'h2101, "source and tag");
        chk_cnt(rx_q.size(), 1, "payload kept");
        chk_val({8'h00, rx_q[0]}, 16'h00a0, "payload byte");
        mark();
        host.send(mk(8'h05, 8'h01, 2, 1'b0));
        expect_ev(0, 1, 0);
        i_max_len <= 16'h0008;
    endtask
    task automatic t_ids();
        logic [7:0] ids[5] = '{TYPE_T, 8'h1c, 8'h1f, 8'h06, BCAST_ID};
        int ex[5] = '{1, 0, 0, 0, 1};
        int rs[5] = '{1, 0, 0, 0, 0};
        int ex2[5] = '{0, 0, 0, 0, 1};
        foreach (ids[i])
        begin
            mark();
            host.send(mk(ids[i], 8'h10 + i[7:0], 1, 1'b0));
            expect_ev(ex[i], rs[i], 0);
            chk_cnt(rx_q.size(), ex[i], "payload count");
            chk_cnt(n[6] - b[6], ex2[i], "reserved type exec");
            chk_cnt(n[7] - b[7], 0, "reserved type resp");
        end
    endtask
    task automatic t_bad();
        host.gap = 2;
        mark();
        host.send({8'h55, 8'h00, mk(8'h05, 8'h20, 1, 1'b1)});
        expect_ev(0, 1, 1);
        chk_val(o_resp_code, RESP_BAD_CSUM, "error code");
        host.gap = 0;
    endtask
    task automatic t_fill();
        i_data_ready <= 1'b0;
        full_seen = 1'b0;
        mark();
        fork
            host.send(mk(8'h05, 8'h21, 6, 1'b0));
            begin
                repeat (20) @(posedge i_ref_clk)
                    if (rx_ready === 1'b0) full_seen = 1'b1;
                i_data_ready <= 1'b1;
            end
        join
        chk_val({15'h0, full_seen}, 16'h0001, "fifo refused");
        expect_ev(1, 1, 0);
        chk_cnt(rx_q.size(), 6, "payload drained");
        foreach (rx_q[i])
            chk_val({8'h00, rx_q[i]}, 16'h00a0 + 16'(i), "fifo order");
    endtask
    task automatic t_timeout();
        rfr_bq_t part;
        part = mk(8'h05, 8'h30, 1, 1'b0);
        part = part[0:3];
        mark();
        host.send(part);
        // the last byte was taken four edges ago; the pulse lands at the
        // edge that ends the allowed gap and is tallied one edge later
        repeat (GAP_T - 4) @(posedge i_ref_clk);
        chk_cnt(n[4] - b[4], 0, "early timeout");
        repeat (2) @(posedge i_ref_clk);
        chk_cnt(n[4] - b[4], 1, "gap timeout");
        chk_cnt(n[1] + n[3] - b[1] - b[3], 0, "silent drop");
        mark();
        host.send(mk(8'h05, 8'h31, 1, 1'b0));
        expect_ev(1, 1, 0);
    endtask
    task automatic t_wait();
        i_wait_en <= 1'b1;
        mark();
        repeat (WAIT_T + 10) @(posedge i_ref_clk);
        chk_cnt(n[5] - b[5], 1, "wait expiry");
        mark();
        host.send(mk(8'h05, 8'h40, 1, 1'b1));
        expect_ev(0, 0, 1);
        i_wait_en <= 1'b0;
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        t_good();
        t_ids();
        t_bad();
        t_fill();
        t_timeout();
        t_wait();
        give_verdict();
    end
    // the whole sequence needs well under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge i_ref_clk);
        err_total++;
        $display("unexpected at %0t: run did not finish", $time);
        give_verdict();
    end
endmodule // tb
